//--- eim_params.svh
// Address, reset and field-position constants of the extended mask block
`ifndef EIM_PARAMS_SVH
`define EIM_PARAMS_SVH

`define EIM_GRP_W 8
`define EIM_NUM_SRC 16

`define EIM_ADDR_ENABLE_ONE 8'hE6
`define EIM_ADDR_ENABLE_TWO 8'hE7
`define EIM_ADDR_PRIORITY_ONE 8'hF6

`define EIM_RST_ENABLE_ONE 8'h00
`define EIM_RST_ENABLE_TWO 8'h00
`define EIM_RST_PRIORITY_ONE 8'h00
`define EIM_RDATA_UNMAPPED 8'h00
`define EIM_LEVEL_TWO_FIXED 8'h00

// Group one positions, shared by mask and level fields
`define EIM_LIN_IRQ_MASK 7
`define EIM_TIMER_THREE_IRQ_MASK 6
`define EIM_COMPARATOR_ONE_IRQ_MASK 5
`define EIM_COMPARATOR_ZERO_IRQ_MASK 4
`define EIM_COUNTER_ARRAY_ZERO_IRQ_MASK 3
`define EIM_CONVERSION_DONE_IRQ_MASK 2
`define EIM_WINDOW_COMPARE_IRQ_MASK 1
`define EIM_SMBUS_IRQ_MASK 0

// Group two positions
`define EIM_TIMER_FIVE_IRQ_MASK 7
`define EIM_TIMER_FOUR_IRQ_MASK 6
`define EIM_COMPARATOR_TWO_IRQ_MASK 5
`define EIM_COUNTER_ARRAY_ONE_IRQ_MASK 4
`define EIM_SERIAL_PORT_TWO_IRQ_MASK 3
`define EIM_PORT_MATCH_IRQ_MASK 2
`define EIM_CAN_IRQ_MASK 1
`define EIM_REGULATOR_DROPOUT_IRQ_MASK 0

`endif

//--- eim_pkg.sv
// Types of the extended mask block
`default_nettype none
`include "eim_params.svh"
package eim_pkg;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_ENABLE_ONE,
        SEL_ENABLE_TWO,
        SEL_PRIORITY_ONE
    } eim_reg_sel_t;
    typedef logic [`EIM_NUM_SRC-1:0] eim_src_vec_t;
endpackage : eim_pkg
`default_nettype wire

//--- eim_gate_if.sv
// Carrier between register logic and the source gate
`timescale 1ns/1ps
`default_nettype none
interface eim_gate_if import eim_pkg::*; ();
    eim_src_vec_t pending;
    eim_src_vec_t enable;
    eim_src_vec_t level;
    logic global_en;
    eim_src_vec_t req_low;
    eim_src_vec_t req_high;
    modport gate (
        input pending, enable, level, global_en,
        output req_low, req_high
    );
    modport ctrl (
        output pending, enable, level, global_en,
        input req_low, req_high
    );
endinterface : eim_gate_if
`default_nettype wire

//--- eim_src_gate.sv
// Per-source gating of pending flags into low and high requests
`timescale 1ns/1ps
`default_nettype none
`include "eim_params.svh"
module eim_src_gate import eim_pkg::*; (
    eim_gate_if.gate gif
);
    genvar i;
    generate
        for (i = 0; i < `EIM_NUM_SRC; i = i + 1) begin : g_src
            assign gif.req_high[i] = gif.global_en & gif.enable[i]
                                   & gif.pending[i] & gif.level[i];
            assign gif.req_low[i] = gif.global_en & gif.enable[i]
                                  & gif.pending[i] & ~gif.level[i];
        end
    endgenerate
endmodule : eim_src_gate
`default_nettype wire

//--- eim_ext_irq_ctrl.sv
// Extended interrupt enable and priority registers with request gating
`timescale 1ns/1ps
`default_nettype none
`include "eim_params.svh"
module eim_ext_irq_ctrl import eim_pkg::*; (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR_EN,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_RD_EN,
    output logic [7:0] SFR_RDATA,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic LIN_PENDING_FLAG,
    input wire logic TIMER_THREE_LOW_OVERFLOW,
    input wire logic TIMER_THREE_HIGH_OVERFLOW,
    input wire logic COMPARATOR_ONE_RISE_FLAG,
    input wire logic COMPARATOR_ONE_FALL_FLAG,
    input wire logic COMPARATOR_ZERO_RISE_FLAG,
    input wire logic COMPARATOR_ZERO_FALL_FLAG,
    input wire logic COUNTER_ARRAY_ZERO_REQ,
    input wire logic CONVERSION_DONE_FLAG,
    input wire logic WINDOW_COMPARE_FLAG,
    input wire logic SMBUS_PORT_REQ,
    input wire logic TIMER_FIVE_LOW_OVERFLOW,
    input wire logic TIMER_FIVE_HIGH_OVERFLOW,
    input wire logic TIMER_FOUR_LOW_OVERFLOW,
    input wire logic TIMER_FOUR_HIGH_OVERFLOW,
    input wire logic COMPARATOR_TWO_RISE_FLAG,
    input wire logic COMPARATOR_TWO_FALL_FLAG,
    input wire logic COUNTER_ARRAY_ONE_REQ,
    input wire logic SERIAL_PORT_TWO_REQ,
    input wire logic PORT_MATCH_REQ,
    input wire logic CAN_CONTROLLER_REQ,
    input wire logic REGULATOR_DROPOUT_REQ,
    output logic [`EIM_NUM_SRC-1:0] IRQ_REQ_LOW,
    output logic [`EIM_NUM_SRC-1:0] IRQ_REQ_HIGH
);

    // Register select from SFR address
    function automatic eim_reg_sel_t reg_decode(input logic [7:0] addr);
        case (addr)
            `EIM_ADDR_ENABLE_ONE: reg_decode = SEL_ENABLE_ONE;
            `EIM_ADDR_ENABLE_TWO: reg_decode = SEL_ENABLE_TWO;
            `EIM_ADDR_PRIORITY_ONE: reg_decode = SEL_PRIORITY_ONE;
            default: reg_decode = SEL_NONE;
        endcase
    endfunction : reg_decode

    logic [7:0] ext_irq_enable_one_reg;
    logic [7:0] ext_irq_enable_two_reg;
    logic [7:0] ext_irq_priority_one_reg;
    logic [7:0] rdata_reg;
    eim_src_vec_t req_low_reg;
    eim_src_vec_t req_high_reg;
    eim_reg_sel_t sel;
    logic [7:0] pend_one;
    logic [7:0] pend_two;

    eim_gate_if gif ();

    assign sel = reg_decode(SFR_ADDR);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ext_irq_enable_one_reg <= `EIM_RST_ENABLE_ONE;
        end else if (SFR_WR_EN && sel == SEL_ENABLE_ONE) begin
            ext_irq_enable_one_reg <= SFR_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ext_irq_enable_two_reg <= `EIM_RST_ENABLE_TWO;
        end else if (SFR_WR_EN && sel == SEL_ENABLE_TWO) begin
            ext_irq_enable_two_reg <= SFR_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ext_irq_priority_one_reg <= `EIM_RST_PRIORITY_ONE;
        end else if (SFR_WR_EN && sel == SEL_PRIORITY_ONE) begin
            ext_irq_priority_one_reg <= SFR_WDATA;
        end
    end

    // Read data, held until the next read
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdata_reg <= `EIM_RDATA_UNMAPPED;
        end else if (SFR_RD_EN) begin
            case (sel)
                SEL_ENABLE_ONE: rdata_reg <= ext_irq_enable_one_reg;
                SEL_ENABLE_TWO: rdata_reg <= ext_irq_enable_two_reg;
                SEL_PRIORITY_ONE: rdata_reg <= ext_irq_priority_one_reg;
                default: rdata_reg <= `EIM_RDATA_UNMAPPED;
            endcase
        end
    end

    // Group one source requests
    always_comb begin
        pend_one = 8'h00;
        pend_one[`EIM_LIN_IRQ_MASK] = LIN_PENDING_FLAG;
        pend_one[`EIM_TIMER_THREE_IRQ_MASK] = TIMER_THREE_LOW_OVERFLOW
                                            | TIMER_THREE_HIGH_OVERFLOW;
        pend_one[`EIM_COMPARATOR_ONE_IRQ_MASK] = COMPARATOR_ONE_RISE_FLAG
                                               | COMPARATOR_ONE_FALL_FLAG;
        pend_one[`EIM_COMPARATOR_ZERO_IRQ_MASK] = COMPARATOR_ZERO_RISE_FLAG
                                                | COMPARATOR_ZERO_FALL_FLAG;
        pend_one[`EIM_COUNTER_ARRAY_ZERO_IRQ_MASK] = COUNTER_ARRAY_ZERO_REQ;
        pend_one[`EIM_CONVERSION_DONE_IRQ_MASK] = CONVERSION_DONE_FLAG;
        pend_one[`EIM_WINDOW_COMPARE_IRQ_MASK] = WINDOW_COMPARE_FLAG;
        pend_one[`EIM_SMBUS_IRQ_MASK] = SMBUS_PORT_REQ;
    end

    // Group two source requests
    always_comb begin
        pend_two = 8'h00;
        pend_two[`EIM_TIMER_FIVE_IRQ_MASK] = TIMER_FIVE_LOW_OVERFLOW
                                           | TIMER_FIVE_HIGH_OVERFLOW;
        pend_two[`EIM_TIMER_FOUR_IRQ_MASK] = TIMER_FOUR_LOW_OVERFLOW
                                           | TIMER_FOUR_HIGH_OVERFLOW;
        pend_two[`EIM_COMPARATOR_TWO_IRQ_MASK] = COMPARATOR_TWO_RISE_FLAG
                                               | COMPARATOR_TWO_FALL_FLAG;
        pend_two[`EIM_COUNTER_ARRAY_ONE_IRQ_MASK] = COUNTER_ARRAY_ONE_REQ;
        pend_two[`EIM_SERIAL_PORT_TWO_IRQ_MASK] = SERIAL_PORT_TWO_REQ;
        pend_two[`EIM_PORT_MATCH_IRQ_MASK] = PORT_MATCH_REQ;
        pend_two[`EIM_CAN_IRQ_MASK] = CAN_CONTROLLER_REQ;
        pend_two[`EIM_REGULATOR_DROPOUT_IRQ_MASK] = REGULATOR_DROPOUT_REQ;
    end

    // Source gate hookup; group two has no level register here
    assign gif.pending = {pend_two, pend_one};
    assign gif.enable = {ext_irq_enable_two_reg, ext_irq_enable_one_reg};
    assign gif.level = {`EIM_LEVEL_TWO_FIXED, ext_irq_priority_one_reg};
    assign gif.global_en = GLOBAL_IRQ_ENABLE;

    eim_src_gate u_gate (
        .gif(gif.gate)
    );

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            req_low_reg <= '0;
            req_high_reg <= '0;
        end else begin
            req_low_reg <= gif.req_low;
            req_high_reg <= gif.req_high;
        end
    end

    assign SFR_RDATA = rdata_reg;
    assign IRQ_REQ_LOW = req_low_reg;
    assign IRQ_REQ_HIGH = req_high_reg;

    // Checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    property p_src_on(logic en, logic fl, int idx);
        (GLOBAL_IRQ_ENABLE && en && fl)
            |=> (IRQ_REQ_LOW[idx] || IRQ_REQ_HIGH[idx]);
    endproperty

    property p_src_off(logic en, int idx);
        !en |=> !(IRQ_REQ_LOW[idx] || IRQ_REQ_HIGH[idx]);
    endproperty

    AST_ENABLE_ONE_RW: assert property (
        (SFR_WR_EN && SFR_ADDR == `EIM_ADDR_ENABLE_ONE) ##1
        (SFR_RD_EN && SFR_ADDR == `EIM_ADDR_ENABLE_ONE && !SFR_WR_EN)
        |=> SFR_RDATA == $past(SFR_WDATA, 2))
        else $error("enable one write not read back");
    AST_ENABLE_ONE_RESET: assert property (
        $fell(RST) |-> ext_irq_enable_one_reg == `EIM_RST_ENABLE_ONE)
        else $error("enable one not zero after reset");
    AST_ENABLE_TWO_RESET: assert property (
        $fell(RST) |-> ext_irq_enable_two_reg == `EIM_RST_ENABLE_TWO)
        else $error("enable two not zero after reset");
    AST_PRIORITY_RESET: assert property (
        $fell(RST) |-> ext_irq_priority_one_reg == `EIM_RST_PRIORITY_ONE)
        else $error("priority one not zero after reset");
    AST_LIN_GATE: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_LIN_IRQ_MASK],
                 LIN_PENDING_FLAG, `EIM_LIN_IRQ_MASK))
        else $error("lin request not raised");
    AST_TIMER_THREE_HIGH: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_TIMER_THREE_IRQ_MASK],
                 TIMER_THREE_HIGH_OVERFLOW, `EIM_TIMER_THREE_IRQ_MASK))
        else $error("timer three high overflow lost");
    AST_TIMER_THREE_LOW: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_TIMER_THREE_IRQ_MASK],
                 TIMER_THREE_LOW_OVERFLOW, `EIM_TIMER_THREE_IRQ_MASK))
        else $error("timer three low overflow lost");
    AST_COMPARATOR_ZERO_FALL: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_COMPARATOR_ZERO_IRQ_MASK],
                 COMPARATOR_ZERO_FALL_FLAG, `EIM_COMPARATOR_ZERO_IRQ_MASK))
        else $error("comparator zero fall lost");
    AST_COMPARATOR_ZERO_RISE: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_COMPARATOR_ZERO_IRQ_MASK],
                 COMPARATOR_ZERO_RISE_FLAG, `EIM_COMPARATOR_ZERO_IRQ_MASK))
        else $error("comparator zero rise lost");
    AST_COMPARATOR_ONE_RISE: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_COMPARATOR_ONE_IRQ_MASK],
                 COMPARATOR_ONE_RISE_FLAG, `EIM_COMPARATOR_ONE_IRQ_MASK))
        else $error("comparator one rise lost");
    AST_COUNTER_ZERO_BLOCK: assert property (
        p_src_off(ext_irq_enable_one_reg[`EIM_COUNTER_ARRAY_ZERO_IRQ_MASK],
                  `EIM_COUNTER_ARRAY_ZERO_IRQ_MASK))
        else $error("counter array zero leaked while masked");
    AST_CONVERSION_GATE: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_CONVERSION_DONE_IRQ_MASK],
                 CONVERSION_DONE_FLAG, `EIM_CONVERSION_DONE_IRQ_MASK))
        else $error("conversion done lost");
    AST_WINDOW_GATE: assert property (
        p_src_on(ext_irq_enable_one_reg[`EIM_WINDOW_COMPARE_IRQ_MASK],
                 WINDOW_COMPARE_FLAG, `EIM_WINDOW_COMPARE_IRQ_MASK))
        else $error("window compare lost");
    AST_SMBUS_BLOCK: assert property (
        p_src_off(ext_irq_enable_one_reg[`EIM_SMBUS_IRQ_MASK],
                  `EIM_SMBUS_IRQ_MASK))
        else $error("smbus leaked while masked");
    AST_PRIORITY_WRITE: assert property (
        (SFR_WR_EN && SFR_ADDR == `EIM_ADDR_PRIORITY_ONE)
        |=> ext_irq_priority_one_reg == $past(SFR_WDATA))
        else $error("priority one write lost");
    AST_LEVEL_HIGH: assert property (
        (IRQ_REQ_HIGH[`EIM_GRP_W-1:0] & ~$past(ext_irq_priority_one_reg))
        == 8'h00)
        else $error("high request from low level source");
    AST_LEVEL_LOW: assert property (
        (IRQ_REQ_LOW[`EIM_GRP_W-1:0] & $past(ext_irq_priority_one_reg))
        == 8'h00)
        else $error("low request from high level source");
    AST_LEVEL_EXCLUSIVE: assert property (
        (IRQ_REQ_LOW & IRQ_REQ_HIGH) == '0)
        else $error("source requests at both levels");
    AST_ENABLE_TWO_WRITE: assert property (
        (SFR_WR_EN && SFR_ADDR == `EIM_ADDR_ENABLE_TWO)
        |=> ext_irq_enable_two_reg == $past(SFR_WDATA))
        else $error("enable two write lost");
    AST_TIMER_FIVE_LOW: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_TIMER_FIVE_IRQ_MASK],
                 TIMER_FIVE_LOW_OVERFLOW, `EIM_GRP_W + 7))
        else $error("timer five low overflow lost");
    AST_TIMER_FIVE_HIGH: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_TIMER_FIVE_IRQ_MASK],
                 TIMER_FIVE_HIGH_OVERFLOW, `EIM_GRP_W + 7))
        else $error("timer five high overflow lost");
    AST_TIMER_FOUR_HIGH: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_TIMER_FOUR_IRQ_MASK],
                 TIMER_FOUR_HIGH_OVERFLOW, `EIM_GRP_W + 6))
        else $error("timer four high overflow lost");
    AST_TIMER_FOUR_LOW: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_TIMER_FOUR_IRQ_MASK],
                 TIMER_FOUR_LOW_OVERFLOW, `EIM_GRP_W + 6))
        else $error("timer four low overflow lost");
    AST_COMPARATOR_TWO_RISE: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_COMPARATOR_TWO_IRQ_MASK],
                 COMPARATOR_TWO_RISE_FLAG, `EIM_GRP_W + 5))
        else $error("comparator two rise lost");
    AST_COMPARATOR_TWO_FALL: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_COMPARATOR_TWO_IRQ_MASK],
                 COMPARATOR_TWO_FALL_FLAG, `EIM_GRP_W + 5))
        else $error("comparator two fall lost");
    AST_COUNTER_ONE_BLOCK: assert property (
        p_src_off(ext_irq_enable_two_reg[`EIM_COUNTER_ARRAY_ONE_IRQ_MASK],
                  `EIM_GRP_W + 4))
        else $error("counter array one leaked while masked");
    AST_SERIAL_TWO_GATE: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_SERIAL_PORT_TWO_IRQ_MASK],
                 SERIAL_PORT_TWO_REQ, `EIM_GRP_W + 3))
        else $error("serial port two lost");
    AST_PORT_MATCH_GATE: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_PORT_MATCH_IRQ_MASK],
                 PORT_MATCH_REQ, `EIM_GRP_W + 2))
        else $error("port match lost");
    AST_CAN_BLOCK: assert property (
        p_src_off(ext_irq_enable_two_reg[`EIM_CAN_IRQ_MASK], `EIM_GRP_W + 1))
        else $error("can leaked while masked");
    AST_DROPOUT_GATE: assert property (
        p_src_on(ext_irq_enable_two_reg[`EIM_REGULATOR_DROPOUT_IRQ_MASK],
                 REGULATOR_DROPOUT_REQ, `EIM_GRP_W))
        else $error("regulator dropout lost");
    AST_GLOBAL_OFF: assert property (
        !GLOBAL_IRQ_ENABLE [*2] |-> (IRQ_REQ_LOW | IRQ_REQ_HIGH) == '0)
        else $error("request while globally disabled");
    AST_REQ_CAUSE: assert property (
        !$past(RST) |-> (IRQ_REQ_LOW | IRQ_REQ_HIGH) ==
        ($past(gif.pending & gif.enable)
         & {`EIM_NUM_SRC{$past(GLOBAL_IRQ_ENABLE)}}))
        else $error("request not flag and mask and global");

    COV_HIGH_REQ: cover property (|IRQ_REQ_HIGH);
    COV_LOW_REQ: cover property (|IRQ_REQ_LOW);
    COV_GLOBAL_BLOCKS: cover property (
        !GLOBAL_IRQ_ENABLE && (|(gif.pending & gif.enable)));
    COV_READBACK: cover property (
        SFR_RD_EN && sel == SEL_PRIORITY_ONE ##1 SFR_RDATA != 8'h00);

endmodule : eim_ext_irq_ctrl
`default_nettype wire

//--- eim_src_model.sv
// Far-side model of the peripheral interrupt sources
`timescale 1ns/1ps
`default_nettype none
module eim_src_model import eim_pkg::*; (
    input wire eim_src_vec_t src_pend,
    input wire logic alt_flag,
    output logic [21:0] src_pins
);
    eim_src_vec_t lo;
    eim_src_vec_t hi;
    // Paired sources raise one of their two flags
    assign lo = src_pend & {16{~alt_flag}};
    assign hi = src_pend & {16{alt_flag}};
    assign src_pins = {lo[15], hi[15], lo[14], hi[14], lo[13], hi[13],
        src_pend[12:8], src_pend[7], lo[6], hi[6], lo[5], hi[5],
        lo[4], hi[4], src_pend[3:0]};
endmodule : eim_src_model
`default_nettype wire

//--- eim_tb.sv
// Self-checking bench of the extended mask block
`timescale 1ns/1ps
`default_nettype none
`include "eim_params.svh"
module tb import eim_pkg::*; ;
    logic core_clk;
    logic rst;
    logic wr_en;
    logic rd_en;
    logic glb;
    logic alt;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [21:0] pin;
    eim_src_vec_t pend;
    eim_src_vec_t req_low;
    eim_src_vec_t req_high;
    int n_mismatch;
    int check_count;

    eim_src_model i_eim_src_model (.src_pend(pend), .alt_flag(alt),
        .src_pins(pin));

    eim_ext_irq_ctrl i_eim_ext_irq_ctrl (
        .CORE_CLK(core_clk), .RST(rst), .SFR_ADDR(addr),
        .SFR_WR_EN(wr_en), .SFR_WDATA(wdata), .SFR_RD_EN(rd_en),
        .SFR_RDATA(rdata), .GLOBAL_IRQ_ENABLE(glb),
        .TIMER_FIVE_LOW_OVERFLOW(pin[21]),
        .TIMER_FIVE_HIGH_OVERFLOW(pin[20]),
        .TIMER_FOUR_LOW_OVERFLOW(pin[19]),
        .TIMER_FOUR_HIGH_OVERFLOW(pin[18]),
        .COMPARATOR_TWO_RISE_FLAG(pin[17]),
        .COMPARATOR_TWO_FALL_FLAG(pin[16]),
        .COUNTER_ARRAY_ONE_REQ(pin[15]), .SERIAL_PORT_TWO_REQ(pin[14]),
        .PORT_MATCH_REQ(pin[13]), .CAN_CONTROLLER_REQ(pin[12]),
        .REGULATOR_DROPOUT_REQ(pin[11]), .LIN_PENDING_FLAG(pin[10]),
        .TIMER_THREE_LOW_OVERFLOW(pin[9]),
        .TIMER_THREE_HIGH_OVERFLOW(pin[8]),
        .COMPARATOR_ONE_RISE_FLAG(pin[7]),
        .COMPARATOR_ONE_FALL_FLAG(pin[6]),
        .COMPARATOR_ZERO_RISE_FLAG(pin[5]),
        .COMPARATOR_ZERO_FALL_FLAG(pin[4]),
        .COUNTER_ARRAY_ZERO_REQ(pin[3]), .CONVERSION_DONE_FLAG(pin[2]),
        .WINDOW_COMPARE_FLAG(pin[1]), .SMBUS_PORT_REQ(pin[0]),
        .IRQ_REQ_LOW(req_low), .IRQ_REQ_HIGH(req_high)
    );

    always #4 core_clk = ~core_clk;

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Write with one idle cycle after
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge core_clk);
        wr_en = 1'b0;
        @(negedge core_clk);
    endtask : sfr_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_en = 1'b1;
        @(negedge core_clk);
        rd_en = 1'b0;
        chk({8'h00, rdata}, {8'h00, exp});
        @(negedge core_clk);
    endtask : rd_chk

    task automatic t_reset_vals;
        rd_chk(`EIM_ADDR_ENABLE_ONE, `EIM_RST_ENABLE_ONE);
        rd_chk(`EIM_ADDR_ENABLE_TWO, `EIM_RST_ENABLE_TWO);
        rd_chk(`EIM_ADDR_PRIORITY_ONE, `EIM_RST_PRIORITY_ONE);
        rd_chk(8'hE5, `EIM_RDATA_UNMAPPED);
        $display("test reset_vals done");
    endtask : t_reset_vals

    task automatic t_readback;
        sfr_wr(`EIM_ADDR_ENABLE_ONE, 8'hA5);
        sfr_wr(`EIM_ADDR_ENABLE_TWO, 8'h5A);
        sfr_wr(`EIM_ADDR_PRIORITY_ONE, 8'h3C);
        sfr_wr(8'hE5, 8'hFF);
        rd_chk(`EIM_ADDR_ENABLE_ONE, 8'hA5);
        rd_chk(`EIM_ADDR_ENABLE_TWO, 8'h5A);
        rd_chk(`EIM_ADDR_PRIORITY_ONE, 8'h3C);
        rd_chk(8'hE5, `EIM_RDATA_UNMAPPED);
        // Write then read back to back
        addr = `EIM_ADDR_ENABLE_ONE;
        wdata = 8'hC3;
        wr_en = 1'b1;
        @(negedge core_clk);
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(negedge core_clk);
        rd_en = 1'b0;
        chk({8'h00, rdata}, 16'h00C3);
        @(negedge core_clk);
        // Write and read together return the old value
        addr = `EIM_ADDR_PRIORITY_ONE;
        wdata = 8'h99;
        wr_en = 1'b1;
        rd_en = 1'b1;
        @(negedge core_clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
        chk({8'h00, rdata}, 16'h003C);
        @(negedge core_clk);
        rd_chk(`EIM_ADDR_PRIORITY_ONE, 8'h99);
        $display("test readback done");
    endtask : t_readback

    task automatic t_mask_walk;
        logic [15:0] exp;
        logic [15:0] hexp;
        glb = 1'b1;
        pend = 16'hFFFF;
        for (int i = 0; i < 16; i++) begin
            for (int a = 0; a < 2; a++) begin
                for (int p = 0; p < 2; p++) begin
                    exp = 16'h0001 << i;
                    alt = a[0];
                    sfr_wr(`EIM_ADDR_ENABLE_ONE, exp[7:0]);
                    sfr_wr(`EIM_ADDR_ENABLE_TWO, exp[15:8]);
                    sfr_wr(`EIM_ADDR_PRIORITY_ONE, p[0] ? 8'hFF : 8'h00);
                    hexp = (p == 1 && i < 8) ? exp : 16'h0000;
                    chk(req_high, hexp);
                    chk(req_low, exp & ~hexp);
                end
            end
        end
        $display("test mask_walk done");
    endtask : t_mask_walk

    task automatic t_global_level;
        sfr_wr(`EIM_ADDR_ENABLE_ONE, 8'hFF);
        sfr_wr(`EIM_ADDR_ENABLE_TWO, 8'hFF);
        sfr_wr(`EIM_ADDR_PRIORITY_ONE, 8'hA5);
        glb = 1'b0;
        @(negedge core_clk);
        chk(req_low | req_high, 16'h0000);
        glb = 1'b1;
        @(negedge core_clk);
        chk(req_high, 16'h00A5);
        chk(req_low, 16'hFF5A);
        pend = 16'h0000;
        @(negedge core_clk);
        chk(req_low | req_high, 16'h0000);
        $display("test global_level done");
    endtask : t_global_level

    task automatic t_mid_reset;
        pend = 16'hFFFF;
        rst = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        chk(req_low | req_high, 16'h0000);
        t_reset_vals();
        $display("test mid_reset done");
    endtask : t_mid_reset

    initial begin
        repeat (5000) @(posedge core_clk);
        $display("watchdog expired");
        n_mismatch = n_mismatch + 1;
        give_verdict();
    end

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        glb = 1'b0;
        alt = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        pend = 16'h0000;
        n_mismatch = 0;
        check_count = 0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        t_reset_vals();
        t_readback();
        t_mask_walk();
        t_global_level();
        t_mid_reset();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
